// >>> logic/dsc_defs.vh
// dsc_defs.vh: shared constants for the dual switch control logic
// assumes inclusion by bare name from the design files
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH
`define DSC_CMD_NONE 3'h0
`define DSC_CMD_DIAG 3'h1
`define DSC_CMD_OUTCFG 3'h2
`define DSC_CMD_IOCFG 3'h3
`define DSC_CMD_RESET 3'h4
`define DSC_CMD_SLEEP 3'h5
`define DSC_CMD_WAKE 3'h6
`define DSC_CMD_ONOFF 3'h7
`define DSC_SRC_PAR 2'h0
`define DSC_SRC_OR 2'h1
`define DSC_SRC_AND 2'h2
`define DSC_SRC_SER 2'h3
`define DSC_PIN_FAULT 2'h0
`define DSC_OUTCFG_RST 5'h00
`define DSC_IOCFG_RST 5'h00
`define DSC_FRAME_BITS 4'h8
`define DSC_SYNC_RST 12'h200
`define DSC_CLK_MHZ 125
`define DSC_TFAULT_US 200
`define DSC_TOFF_US 50
`define DSC_TWAKE_US 100
`endif

// >>> logic/dsc_filter.v
// dsc_filter.v: per-channel persistence timer for overload filtering
// assumes run_i is synchronous to clk_sys_i
`timescale 1ns/1ps
module dsc_filter #(
  parameter WIDTH = 16,
  parameter LIMIT = 25000
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire run_i,
  output reg hit_o
);
  reg [WIDTH-1:0] count;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i || !run_i) begin
      count <= {WIDTH{1'b0}};
      hit_o <= 1'b0;
    end else if (count == LIMIT[WIDTH-1:0] - 1'b1) begin
      hit_o <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// >>> logic/dsc_top.v
// dsc_top.v: control and protection logic of a two-channel low-side switch
// assumes a serial master on cs/sclk/si; sensors are async level inputs
// Notes on behaviour
// - each channel follows parallel pin, serial bit, or their combination
// - parallel pins and serial bits are active high
// - OR mode on if either high; AND mode on if both high
// - one output latch per channel, set by its serial data bit
// - per-channel slew select, fast or slow in ratio one to five
// - overtemperature turns channel off at once and flags diagnosis
// - autorestart turns channel back on after cooling while input requests on
// - latching mode holds channel off until input rising edge
// - channel overtemperature sensor evaluated only while channel on
// - die overtemperature raises a separate warning flag
// - sleep turns outputs off and clears diagnosis and on/off register
// - wake command starts delay; full function after wake delay
// - configuration registers survive sleep and wake
// - after wake outputs stay off unless parallel controlled
// - limit 1 limits current; persistent limiting longer than filter is stored
// - limit 2 turns channel off after delay; cleared by input rising edge
// - overload mode may change while channel runs
// - fault pin low while diagnosis holds an error, high when cleared
// - status 1 copies input 1, inverted when channel 1 has error
// - second pin is serial out or status 2, likewise inverted on error
// - second pin defaults to status 2 until i/o configure sets it
// - four-pin serial port, active-low select, eight-bit shift register
// - sample on falling sclk, shift out on rising sclk, msb first
// - source field 00 par, 01 or, 10 and, 11 serial only
// - overload bit zero selects limit 2, one selects limit 1
// - in sleep every command except wake is ignored
`timescale 1ns/1ps
`include "dsc_defs.vh"
module dsc_top #(
  parameter FAULT_CYC = `DSC_TFAULT_US * `DSC_CLK_MHZ,
  parameter TOFF_CYC = `DSC_TOFF_US * `DSC_CLK_MHZ,
  parameter WAKE_CYC = `DSC_TWAKE_US * `DSC_CLK_MHZ
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire parallel_input_ch1_i,
  input wire parallel_input_ch2_i,
  input wire spi_cs_b_i,
  input wire spi_sclk_i,
  input wire spi_si_i,
  input wire [1:0] chan_overtemp_i,
  input wire [1:0] chan_limiting_i,
  input wire die_overtemp_i,
  input wire [1:0] open_load_i,
  output reg [1:0] chan_on_o,
  output reg [1:0] slow_slew_o,
  output reg [1:0] limit1_sel_o,
  output reg [1:0] sense_sel_o,
  output reg sense_enable_o,
  output reg bias_enable_o,
  output reg overtemp_warn_o,
  output reg sense_fault_status1_pin_o,
  output reg sense_fault_status1_pin_oe_o,
  output reg serial_out_or_status2_pin_o,
  output reg serial_out_or_status2_pin_oe_o,
  output reg sleeping_o
);
  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_WAKE = 2'h2;

  // two-flop synchronisers for every asynchronous input
  wire [11:0] async_in = {parallel_input_ch1_i, parallel_input_ch2_i,
    spi_cs_b_i, spi_sclk_i, spi_si_i, chan_overtemp_i, chan_limiting_i,
    die_overtemp_i, open_load_i};
  reg [11:0] sync_a;
  reg [11:0] sync_b;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      // select resets to its idle high level, so no false edge after reset
      sync_a <= `DSC_SYNC_RST;
      sync_b <= `DSC_SYNC_RST;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end
  wire [1:0] par_in = {sync_b[10], sync_b[11]};
  wire cs_b = sync_b[9];
  wire sclk = sync_b[8];
  wire si = sync_b[7];
  wire [1:0] ot_in = sync_b[6:5];
  wire [1:0] lim_in = sync_b[4:3];
  wire die_ot = sync_b[2];
  wire [1:0] ol_in = sync_b[1:0];

  reg cs_d;
  reg sclk_d;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_b;
      sclk_d <= sclk;
    end
  end
  wire cs_fall = cs_d && !cs_b;
  wire cs_rise = !cs_d && cs_b;
  wire sclk_fall = !cs_b && sclk_d && !sclk;
  wire sclk_rise = !cs_b && !sclk_d && sclk;

  // configuration: outcfg {ilim2, ilim1, latch, slew2, slew1}
  reg [4:0] outcfg;
  // iocfg {spi_sel, src[1:0], pinfn[1:0]}
  reg [4:0] iocfg;
  reg [1:0] ser_on;
  reg [1:0] state;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg [3:0] bit_cnt;
  reg [1:0] ot_latch;
  reg [1:0] ol_latch;
  reg [1:0] lim1_flt;
  reg [1:0] ol_flt;
  reg [1:0] ctl_d;
  reg warn;
  reg [31:0] wake_cnt;

  wire [1:0] src = iocfg[3:2];
  wire latch_mode = outcfg[2];
  wire [1:0] ilim = outcfg[4:3];
  wire spi_sel = iocfg[4];
  wire active = (state == ST_RUN);

  // effective control request per channel
  reg [1:0] ctl;
  always @* begin
    case (src)
      `DSC_SRC_PAR: ctl = par_in;
      `DSC_SRC_OR: ctl = par_in | ser_on;
      `DSC_SRC_AND: ctl = par_in & ser_on;
      default: ctl = ser_on;
    endcase
  end
  wire [1:0] ctl_rise = ctl & ~ctl_d;

  wire [1:0] lim1_hit;
  wire [1:0] off_hit;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      // limit 1 filter counts only while limiting in limit 1 mode
      dsc_filter #(.WIDTH(32), .LIMIT(FAULT_CYC)) u_flt1 (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .run_i(chan_on_o[g] && lim_in[g] && ilim[g]),
        .hit_o(lim1_hit[g])
      );
      // limit 2 switch-off delay; mode bit read live so change applies
      dsc_filter #(.WIDTH(32), .LIMIT(TOFF_CYC)) u_flt2 (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .run_i(chan_on_o[g] && lim_in[g] && !ilim[g]),
        .hit_o(off_hit[g])
      );
    end
  endgenerate

  wire [7:0] cmd = shift_in;
  wire frame_ok = cs_rise && (bit_cnt == `DSC_FRAME_BITS);
  wire take = frame_ok && (active || cmd[7:5] == `DSC_CMD_WAKE);
  wire valid_cmd = take && (cmd[7:5] != `DSC_CMD_NONE);
  wire do_reset = take && active && cmd[7:5] == `DSC_CMD_RESET;
  wire do_sleep = take && active && cmd[7:5] == `DSC_CMD_SLEEP;
  wire clr_diag = valid_cmd && active;
  wire [7:0] diag = {warn, 1'b0, ol_in, ot_latch, ol_flt | lim1_flt};
  wire [1:0] ch_err = ot_latch | ol_flt | lim1_flt;

  // serial port and command decode
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt <= 4'h0;
      outcfg <= `DSC_OUTCFG_RST;
      iocfg <= `DSC_IOCFG_RST;
      ser_on <= 2'h0;
      state <= ST_RUN;
      wake_cnt <= 32'h0;
    end else begin
      if (cs_fall) begin
        // no diagnosis load while asleep
        shift_out <= active ? diag : 8'h00;
        bit_cnt <= 4'h0;
      end else if (sclk_fall && bit_cnt != `DSC_FRAME_BITS) begin
        shift_in <= {shift_in[6:0], si};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (sclk_rise && bit_cnt != 4'h0) begin
        // first rising edge keeps the msb loaded at select fall
        shift_out <= {shift_out[6:0], 1'b0};
      end
      if (take && active) begin
        case (cmd[7:5])
          `DSC_CMD_OUTCFG: outcfg <= cmd[4:0];
          `DSC_CMD_IOCFG: iocfg <= cmd[4:0];
          `DSC_CMD_RESET: begin
            outcfg <= `DSC_OUTCFG_RST;
            iocfg <= `DSC_IOCFG_RST;
            ser_on <= 2'h0;
          end
          `DSC_CMD_ONOFF: ser_on <= {cmd[4], cmd[3]};
          default: ser_on <= ser_on;
        endcase
      end
      case (state)
        ST_RUN: if (do_sleep) begin
          state <= ST_SLEEP;
          ser_on <= 2'h0;
        end
        ST_SLEEP: if (take) begin
          state <= ST_WAKE;
          wake_cnt <= 32'h0;
        end
        ST_WAKE: begin
          if (wake_cnt == WAKE_CYC - 1)
            state <= ST_RUN;
          else
            wake_cnt <= wake_cnt + 32'h1;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // protection latches; a new fault wins over a diagnosis clear, but a reset command clears the per-channel latches regardless
  integer i;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ot_latch <= 2'h0;
      ol_latch <= 2'h0;
      lim1_flt <= 2'h0;
      ol_flt <= 2'h0;
      warn <= 1'b0;
      ctl_d <= 2'h0;
    end else begin
      ctl_d <= ctl;
      for (i = 0; i < 2; i = i + 1) begin
        if (!active || do_reset) begin
          ot_latch[i] <= 1'b0;
          ol_latch[i] <= 1'b0;
          lim1_flt[i] <= 1'b0;
          ol_flt[i] <= 1'b0;
        end else begin
          if (chan_on_o[i] && ot_in[i])
            ot_latch[i] <= 1'b1;
          else if (!latch_mode && !ot_in[i])
            ot_latch[i] <= 1'b0;
          else if (latch_mode && ctl_rise[i])
            ot_latch[i] <= 1'b0;
          if (off_hit[i])
            ol_latch[i] <= 1'b1;
          else if (ctl_rise[i])
            ol_latch[i] <= 1'b0;
          // reported copy clears on any valid command other than none; the off latch on a control rising edge, the reset command or outside run state
          if (off_hit[i])
            ol_flt[i] <= 1'b1;
          else if (clr_diag)
            ol_flt[i] <= 1'b0;
          if (lim1_hit[i])
            lim1_flt[i] <= 1'b1;
          else if (clr_diag)
            lim1_flt[i] <= 1'b0;
        end
      end
      if (die_ot && active)
        warn <= 1'b1;
      else if (clr_diag || !active)
        warn <= 1'b0;
    end
  end

  // outputs, all registered
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      chan_on_o <= 2'h0;
      slow_slew_o <= 2'h0;
      limit1_sel_o <= 2'h0;
      sense_sel_o <= 2'h0;
      sense_enable_o <= 1'b0;
      bias_enable_o <= 1'b1;
      overtemp_warn_o <= 1'b0;
      sense_fault_status1_pin_o <= 1'b0;
      sense_fault_status1_pin_oe_o <= 1'b0;
      serial_out_or_status2_pin_o <= 1'b0;
      serial_out_or_status2_pin_oe_o <= 1'b0;
      sleeping_o <= 1'b0;
    end else begin
      // ot/overload latches force off; wake keeps serial bits cleared
      chan_on_o <= active ? (ctl & ~ot_latch & ~ol_latch) : 2'h0;
      slow_slew_o <= outcfg[1:0];
      limit1_sel_o <= ilim;
      sense_sel_o <= iocfg[1:0];
      sense_enable_o <= active && spi_sel && iocfg[1:0] != `DSC_PIN_FAULT;
      bias_enable_o <= (state != ST_SLEEP);
      overtemp_warn_o <= warn;
      sleeping_o <= (state == ST_SLEEP);
      // open drain: enable pulls low, pin value is always low
      sense_fault_status1_pin_o <= 1'b0;
      if (spi_sel)
        sense_fault_status1_pin_oe_o <= iocfg[1:0] == `DSC_PIN_FAULT &&
          (|ch_err || warn);
      else
        sense_fault_status1_pin_oe_o <= !(par_in[0] ^ ch_err[0]);
      if (spi_sel) begin
        // push-pull serial out, released while select is high
        serial_out_or_status2_pin_o <= shift_out[7];
        serial_out_or_status2_pin_oe_o <= !cs_b;
      end else begin
        serial_out_or_status2_pin_o <= 1'b0;
        serial_out_or_status2_pin_oe_o <= !(par_in[1] ^ ch_err[1]);
      end
    end
  end
endmodule

// >>> verification/dsc_assertions.sv
// dsc_assertions.sv: port-level checks for dsc_top
// assumes binding into dsc_top; async inputs settle within 4 cycles
`timescale 1ns/1ps
module dsc_assertions (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire spi_cs_b_i,
  input wire [1:0] chan_overtemp_i,
  input wire die_overtemp_i,
  input wire [1:0] chan_on_o,
  input wire [1:0] slow_slew_o,
  input wire [1:0] limit1_sel_o,
  input wire bias_enable_o,
  input wire overtemp_warn_o,
  input wire sense_fault_status1_pin_o,
  input wire sleeping_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  reg cs_q;
  reg [7:0] cs_age;
  // age saturates so a long idle never wraps into a false window
  always @(posedge clk_sys_i) begin
    cs_q <= spi_cs_b_i;
    if (!rst_b_i || (spi_cs_b_i && !cs_q))
      cs_age <= 8'h00;
    else if (cs_age != 8'hFF)
      cs_age <= cs_age + 8'h01;
  end
  a_sleep_off: assert property (
    sleeping_o && $past(sleeping_o, 2) |-> chan_on_o == 2'h0)
    else $error("channel on during sleep");
  a_sleep_bias: assert property (
    sleeping_o && $past(sleeping_o, 2) |-> !bias_enable_o)
    else $error("bias on during sleep");
  a_cfg_on_cs: assert property (
    $changed(slow_slew_o) || $changed(limit1_sel_o) |-> cs_age < 8'h0C)
    else $error("config changed without select rise");
  a_sleep_on_cs: assert property (
    $rose(sleeping_o) |-> cs_age < 8'h0C)
    else $error("sleep entered without select rise");
  a_sleep_hold: assert property (
    $rose(sleeping_o) |=> sleeping_o [*8])
    else $error("sleep left too early");
  a_ot_cut: assert property (
    chan_overtemp_i[0] [*4] ##0 chan_on_o[0] |-> ##[1:3] !chan_on_o[0])
    else $error("hot channel stayed on");
  a_warn_raise: assert property (
    (die_overtemp_i && !sleeping_o) [*4] |-> ##[0:3] overtemp_warn_o)
    else $error("die warning missing");
  a_fault_od: assert property (
    !sense_fault_status1_pin_o)
    else $error("fault pin driven high");
  cover property ($rose(sleeping_o));
  cover property (chan_overtemp_i[0] && chan_on_o[0]);
  cover property ($rose(overtemp_warn_o));
endmodule

// >>> verification/dsc_spi_master.sv
// dsc_spi_master.sv: behavioural serial master for dsc_top
// assumes sclk idles low and si falls to its pull-down between frames
// reads the serial out line on every falling sclk into rx
`timescale 1ns/1ps
module dsc_spi_master (
  input wire spi_so_i,
  output reg spi_cs_b_o,
  output reg spi_sclk_o,
  output reg spi_si_o
);
  integer i;
  reg [7:0] rx;
  initial begin
    rx = 8'h00;
    spi_cs_b_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_si_o = 1'b0;
  end
  // sclk low whenever select moves, so no false edge is counted
  task xfer(input [7:0] w);
    begin
      spi_cs_b_o = 1'b0;
      #200;
      for (i = 7; i >= 0; i = i - 1) begin
        spi_si_o = w[i];
        spi_sclk_o = 1'b1;
        #62.5;
        rx = {rx[6:0], spi_so_i};
        spi_sclk_o = 1'b0;
        #62.5;
      end
      #200;
      spi_cs_b_o = 1'b1;
      spi_si_o = 1'b0;
      #400;
    end
  endtask
endmodule

// >>> verification/dsc_top_tb_top.sv
// dsc_top_tb_top.sv: self-checking bench for dsc_top
// assumes dsc_spi_master drives the serial port; other inputs at negedge
`timescale 1ns/1ps
module dsc_top_tb_top;
  reg clk_sys_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [1:0] par = 2'h0;
  reg [1:0] ot = 2'h0;
  reg [1:0] lim = 2'h0;
  reg die = 1'b0;
  reg [15:0] rnd = 16'h8747;
  reg [4:0] w;
  wire cs_b, sclk, si, fo, foe, so, soe, slp, bias, warn, sen;
  wire [1:0] on, slew, l1, ssel;
  integer n_errors = 0;
  integer num_checks = 0;
  integer k;
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // a released line shows the inverse, so a late drive is caught
  dsc_spi_master u_dsc_spi_master (.spi_so_i(soe ? so : ~so),
    .spi_cs_b_o(cs_b), .spi_sclk_o(sclk), .spi_si_o(si));
  dsc_top #(.FAULT_CYC(20), .TOFF_CYC(20), .WAKE_CYC(20)) u_dsc_top (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .parallel_input_ch1_i(par[0]),
    .parallel_input_ch2_i(par[1]), .spi_cs_b_i(cs_b), .spi_sclk_i(sclk),
    .spi_si_i(si), .chan_overtemp_i(ot), .chan_limiting_i(lim),
    .die_overtemp_i(die), .open_load_i(2'h0), .chan_on_o(on),
    .slow_slew_o(slew), .limit1_sel_o(l1), .sense_sel_o(ssel),
    .sense_enable_o(sen), .bias_enable_o(bias), .overtemp_warn_o(warn),
    .sense_fault_status1_pin_o(fo), .sense_fault_status1_pin_oe_o(foe),
    .serial_out_or_status2_pin_o(so), .serial_out_or_status2_pin_oe_o(soe),
    .sleeping_o(slp));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [1:0] exp_on(input [1:0] m, input [1:0] p, input [1:0] s);
    case (m)
      2'h0: exp_on = p;
      2'h1: exp_on = p | s;
      2'h2: exp_on = p & s;
      default: exp_on = s;
    endcase
  endfunction
  task cyc(input integer n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task send(input [7:0] c);
    begin
      u_dsc_spi_master.xfer(c);
      cyc(2);
    end
  endtask
  task chk(input [8*8:1] nm, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      if (n_errors == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    cyc(12);
    rst_b_i = 1'b1;
    cyc(6);
    chk("on", 2'h0, on);
    chk("st2_oe", 2'h1, {1'b0, soe});
    par = 2'h2;
    cyc(6);
    chk("st2_oe", 2'h0, {1'b0, soe});
    chk("st1_oe", 2'h1, {1'b0, foe});
    for (k = 0; k < 16; k = k + 1) begin
      rnd = lfsr(rnd);
      w = rnd[8:4];
      send({3'h3, 1'b0, k[1:0], 2'h0});
      send({3'h7, rnd[1:0], 3'h0});
      par = rnd[3:2];
      cyc(6);
      chk("on", exp_on(k[1:0], rnd[3:2], rnd[1:0]), on);
      send({3'h2, w});
      chk("slew", w[1:0], slew);
      chk("lim1", w[4:3], l1);
    end
    send(8'h40);
    send(8'h60);
    par = 2'h1;
    cyc(6);
    ot = 2'h1;
    cyc(6);
    chk("on", 2'h0, on);
    chk("st1_oe", 2'h1, {1'b0, foe});
    ot = 2'h0;
    cyc(6);
    chk("on", 2'h1, on);
    chk("st1_oe", 2'h0, {1'b0, foe});
    send(8'h44);
    ot = 2'h3;
    cyc(6);
    ot = 2'h0;
    par = 2'h3;
    cyc(6);
    chk("on", 2'h2, on);
    par = 2'h2;
    cyc(4);
    par = 2'h3;
    cyc(6);
    chk("on", 2'h3, on);
    send(8'h40);
    send(8'h70);
    chk("so_oe", 2'h0, {1'b0, soe});
    lim = 2'h1;
    cyc(40);
    chk("on", 2'h2, on);
    chk("flt_oe", 2'h1, {1'b0, foe});
    lim = 2'h0;
    send(8'h20);
    chk("so_rx", 8'h01, u_dsc_spi_master.rx);
    chk("flt_oe", 2'h0, {1'b0, foe});
    send(8'h48);
    par = 2'h2;
    cyc(4);
    par = 2'h3;
    lim = 2'h1;
    cyc(40);
    chk("on", 2'h3, on);
    chk("flt_oe", 2'h1, {1'b0, foe});
    send(8'h40);
    chk("on", 2'h2, on);
    lim = 2'h0;
    send(8'h71);
    chk("ssel", 2'h1, ssel);
    chk("sen", 2'h1, {1'b0, sen});
    chk("flt_oe", 2'h0, {1'b0, foe});
    die = 1'b1;
    cyc(8);
    chk("warn", 2'h1, {1'b0, warn});
    die = 1'b0;
    send(8'h20);
    chk("warn", 2'h0, {1'b0, warn});
    send(8'h43);
    send(8'h60);
    send(8'hA0);
    chk("sleep", 2'h1, {1'b0, slp});
    chk("on", 2'h0, on);
    chk("bias", 2'h0, {1'b0, bias});
    send(8'h40);
    chk("slew", 2'h3, slew);
    send(8'hC0);
    k = 0;
    while (slp === 1'b1 && k < 200) begin
      cyc(1);
      k = k + 1;
    end
    chk("sleep", 2'h0, {1'b0, slp});
    cyc(4);
    chk("on", 2'h3, on);
    chk("slew", 2'h3, slew);
    conclude;
  end
endmodule
bind dsc_top dsc_assertions u_dsc_assertions (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .spi_cs_b_i(spi_cs_b_i),
  .chan_overtemp_i(chan_overtemp_i), .die_overtemp_i(die_overtemp_i),
  .chan_on_o(chan_on_o), .slow_slew_o(slow_slew_o),
  .limit1_sel_o(limit1_sel_o), .bias_enable_o(bias_enable_o),
  .overtemp_warn_o(overtemp_warn_o),
  .sense_fault_status1_pin_o(sense_fault_status1_pin_o),
  .sleeping_o(sleeping_o));
